// >>> hxp_pkg.sv
// hxp_pkg: shared constants of the host transfer-parameter port and its direct fifo path.
// assumes both ends and the interface refer to these names with an explicit package prefix.
package hxp_pkg;

  // pin bus widths and fifo depth
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 16;

  // device register map, byte offsets on the parallel bus
  localparam logic [7:0] OFS_XFER_MODE      = 8'h50;
  localparam logic [7:0] OFS_SEND_ADDR      = 8'h54;
  localparam logic [7:0] OFS_SEND_COUNT     = 8'h58;
  localparam logic [7:0] OFS_RECV_ADDR      = 8'h5C;
  localparam logic [7:0] OFS_RECV_COUNT     = 8'h60;
  localparam logic [7:0] OFS_BYTES_MOVED    = 8'h64;
  localparam logic [7:0] OFS_COMMAND_ARG    = 8'h68;
  localparam logic [7:0] OFS_CONFIG_NUMBER  = 8'h6C;
  localparam logic [7:0] OFS_IFACE_NUMBER   = 8'h70;
  localparam logic [7:0] FIFO_ADDR          = 8'hFF;

  // field layouts
  localparam int unsigned MODE_W  = 2;
  localparam int unsigned BYTE_W  = 8;
  localparam logic [1:0]  MODE_CODE_DMA  = 2'h1;
  localparam logic [1:0]  MODE_CODE_FIFO = 2'h2;

  // reset value of every parameter register
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // host controller registers, avalon word index
  localparam logic [2:0] HOST_TARGET = 3'h0;
  localparam logic [2:0] HOST_WDATA  = 3'h1;
  localparam logic [2:0] HOST_RDATA  = 3'h2;
  localparam logic [2:0] HOST_CTRL   = 3'h3;
  localparam logic [2:0] HOST_STATUS = 3'h4;
  localparam int unsigned CTRL_WRITE_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;

endpackage : hxp_pkg

// >>> hxp_bus_if.sv
// hxp_bus_if: the asynchronous parallel bus between system processor and device.
// assumes each end drives only its own enables; the shared data wire is resolved here.
`timescale 1ns/1ps
interface hxp_bus_if;
  logic                        cs_n;
  logic                        oe_n;
  logic                        we_n;
  logic [hxp_pkg::ADDR_W-1:0]  addr;
  logic [hxp_pkg::DATA_W-1:0]  host_data;
  logic                        host_data_oe;
  logic [hxp_pkg::DATA_W-1:0]  dev_data;
  logic                        dev_data_oe;
  logic                        wait_n;
  logic [hxp_pkg::DATA_W-1:0]  data_bus;

  // undriven bus reads as zero rather than floating
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);

  modport device (input cs_n, oe_n, we_n, addr, data_bus, output dev_data, dev_data_oe, wait_n);
  modport host   (output cs_n, oe_n, we_n, addr, host_data, host_data_oe, input data_bus, wait_n);
endinterface : hxp_bus_if

// >>> hxp_fifo.sv
// hxp_fifo: small synchronous fifo holding words for direct fifo reads.
// assumes one clock; push and pop may coincide.
`timescale 1ns/1ps
module hxp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  input  wire logic             push_valid_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  output logic                  push_ready_out,
  output logic                  pop_valid_out,
  output logic [WIDTH-1:0]      pop_data_out,
  input  wire logic             pop_in
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             ready_q;
  logic             push;
  logic             pop;

  assign push = push_valid_in && ready_q;
  assign pop  = pop_in && (count_q != '0);
  assign count_d = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_next

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= push_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      count_q <= count_d;
      // ready kept in a flop so the port comes straight from a register
      ready_q <= (count_d != (PW+1)'(DEPTH));
    end
  end

  assign push_ready_out = ready_q;
  assign pop_valid_out  = (count_q != '0);
  assign pop_data_out   = mem[rd_ptr_q];
endmodule : hxp_fifo

// >>> hxp_device.sv
// hxp_device: device end of the parallel host port; parameter registers and direct fifo.
// assumes the bus pins come from another clock domain and are synchronised here;
// the usb-processor side runs on ref_clk_in.
// Operation
// - mode field bits 1:0, 01 dma, 02 fifo
// - software writes zeros to reserved bits
// - all parameter registers reset to zero
// - send address holds 32-bit buffer start
// - send count holds 32-bit buffer size
// - receive address holds 32-bit buffer start
// - receive count holds 32-bit buffer size
// - usb side loads moved byte count
// - software places 8-bit command argument
// - usb side loads 8-bit configuration number
// - usb side loads 8-bit interface number
// - usb-written reserved bits stay zero
// - address FF reaches the fifo
// - fifo pushed and pulled by plain cycles
// - processor drives FF before chip select
// - chip select makes device assert wait
// - output enable drives one fifo word
// - wait released once word is valid
// - one word per read, oe then cs
// - 32-bit registers, aligned addresses only
// - forbidden reads give zero, writes ignored
// - transfer mode register at offset 50
`timescale 1ns/1ps
module hxp_device #(
  parameter int unsigned FIFO_DEPTH = hxp_pkg::FIFO_DEPTH
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        srst_in,
  hxp_bus_if.device                        bus,
  input  wire logic                        usb_report_in,
  input  wire logic [hxp_pkg::DATA_W-1:0]  moved_byte_count_in,
  input  wire logic [hxp_pkg::BYTE_W-1:0]  config_index_in,
  input  wire logic [hxp_pkg::BYTE_W-1:0]  interface_index_in,
  input  wire logic                        usb_word_valid_in,
  input  wire logic [hxp_pkg::DATA_W-1:0]  usb_word_in,
  output logic                             usb_word_ready_out,
  output logic [hxp_pkg::MODE_W-1:0]       xfer_mode_field_out,
  output logic [hxp_pkg::DATA_W-1:0]       outbound_start_out,
  output logic [hxp_pkg::DATA_W-1:0]       outbound_size_out,
  output logic [hxp_pkg::DATA_W-1:0]       inbound_start_out,
  output logic [hxp_pkg::DATA_W-1:0]       inbound_size_out,
  output logic [hxp_pkg::BYTE_W-1:0]       command_argument_field_out,
  output logic                             host_word_valid_out,
  output logic [hxp_pkg::DATA_W-1:0]       host_word_out
);
  localparam int unsigned AW = hxp_pkg::ADDR_W;
  localparam int unsigned DW = hxp_pkg::DATA_W;
  localparam int unsigned SW = 3 + AW + DW;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_SHOW = 2'b10,
    ST_HOLD = 2'b11
  } hxp_dev_state_t;

  hxp_dev_state_t st_q;

  logic [SW-1:0] pin_meta_q;
  logic [SW-1:0] pin_sync_q;
  logic          cs_s;
  logic          oe_s;
  logic          we_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;

  logic [hxp_pkg::MODE_W-1:0] mode_q;
  logic [DW-1:0]              send_addr_q;
  logic [DW-1:0]              send_count_q;
  logic [DW-1:0]              recv_addr_q;
  logic [DW-1:0]              recv_count_q;
  logic [DW-1:0]              moved_q;
  logic [hxp_pkg::BYTE_W-1:0] cmd_arg_q;
  logic [hxp_pkg::BYTE_W-1:0] config_q;
  logic [hxp_pkg::BYTE_W-1:0] iface_q;

  logic          wait_n_q;
  logic          data_oe_q;
  logic [DW-1:0] data_q;
  logic          fifo_rd_q;
  logic          host_word_valid_q;
  logic [DW-1:0] host_word_q;
  logic          bus_write;
  logic          fifo_pop;
  logic          fifo_valid;
  logic [DW-1:0] fifo_word;

  // pins pass two flops before any logic looks at them
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= {bus.cs_n, bus.oe_n, bus.we_n, bus.addr, bus.data_bus};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign cs_s   = pin_sync_q[SW-1];
  assign oe_s   = pin_sync_q[SW-2];
  assign we_s   = pin_sync_q[SW-3];
  assign addr_s = pin_sync_q[DW +: AW];
  assign data_s = pin_sync_q[DW-1:0];

  // misaligned addresses other than the fifo address FF decode to nothing
  function automatic logic word_ok(input logic [AW-1:0] a);
    word_ok = (a[1:0] == 2'b00);
  endfunction : word_ok

  function automatic logic [DW-1:0] reg_rdata(input logic [AW-1:0] a);
    reg_rdata = hxp_pkg::REG_RESET;
    if (word_ok(a)) begin
      case (a)
        hxp_pkg::OFS_XFER_MODE:     reg_rdata = DW'(mode_q);
        hxp_pkg::OFS_SEND_ADDR:     reg_rdata = send_addr_q;
        hxp_pkg::OFS_SEND_COUNT:    reg_rdata = send_count_q;
        hxp_pkg::OFS_RECV_ADDR:     reg_rdata = recv_addr_q;
        hxp_pkg::OFS_RECV_COUNT:    reg_rdata = recv_count_q;
        hxp_pkg::OFS_BYTES_MOVED:   reg_rdata = moved_q;
        hxp_pkg::OFS_COMMAND_ARG:   reg_rdata = DW'(cmd_arg_q);
        hxp_pkg::OFS_CONFIG_NUMBER: reg_rdata = DW'(config_q);
        hxp_pkg::OFS_IFACE_NUMBER:  reg_rdata = DW'(iface_q);
        default:                    reg_rdata = hxp_pkg::REG_RESET;
      endcase
    end
  endfunction : reg_rdata

  // a write is taken once, in the cycle the read-or-write decision is made
  assign bus_write = (st_q == ST_READ) && !we_s;
  assign fifo_pop  = (st_q == ST_HOLD) && cs_s && fifo_rd_q;

  // bus cycle sequencer
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_q      <= ST_IDLE;
      wait_n_q  <= 1'b1;
      data_oe_q <= 1'b0;
      data_q    <= '0;
      fifo_rd_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (!cs_s) begin
            wait_n_q  <= 1'b0;
            fifo_rd_q <= 1'b0;
            st_q      <= ST_READ;
          end
        end
        ST_READ: begin
          if (!we_s) begin
            st_q <= ST_HOLD;
          end else if (!oe_s && (addr_s != hxp_pkg::FIFO_ADDR)) begin
            data_q    <= reg_rdata(addr_s);
            data_oe_q <= 1'b1;
            st_q      <= ST_SHOW;
          end else if (!oe_s && fifo_valid) begin
            // an empty fifo keeps the processor stalled until a word arrives
            data_q    <= fifo_word;
            data_oe_q <= 1'b1;
            fifo_rd_q <= 1'b1;
            st_q      <= ST_SHOW;
          end else if (cs_s) begin
            wait_n_q <= 1'b1;
            st_q     <= ST_IDLE;
          end
        end
        ST_SHOW: begin
          wait_n_q <= 1'b1;
          st_q     <= ST_HOLD;
        end
        ST_HOLD: begin
          wait_n_q <= 1'b1;
          if (oe_s || cs_s) begin
            data_oe_q <= 1'b0;
          end
          if (cs_s) begin
            fifo_rd_q <= 1'b0;
            st_q      <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // software-written parameter registers
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mode_q       <= hxp_pkg::MODE_W'(hxp_pkg::REG_RESET);
      send_addr_q  <= hxp_pkg::REG_RESET;
      send_count_q <= hxp_pkg::REG_RESET;
      recv_addr_q  <= hxp_pkg::REG_RESET;
      recv_count_q <= hxp_pkg::REG_RESET;
      cmd_arg_q    <= hxp_pkg::BYTE_W'(hxp_pkg::REG_RESET);
    end else if (bus_write && word_ok(addr_s)) begin
      case (addr_s)
        hxp_pkg::OFS_XFER_MODE:   mode_q       <= data_s[hxp_pkg::MODE_W-1:0];
        hxp_pkg::OFS_SEND_ADDR:   send_addr_q  <= data_s;
        hxp_pkg::OFS_SEND_COUNT:  send_count_q <= data_s;
        hxp_pkg::OFS_RECV_ADDR:   recv_addr_q  <= data_s;
        hxp_pkg::OFS_RECV_COUNT:  recv_count_q <= data_s;
        hxp_pkg::OFS_COMMAND_ARG: cmd_arg_q    <= data_s[hxp_pkg::BYTE_W-1:0];
        default: ;
      endcase
    end
  end

  // usb-processor-written registers; only the field is stored so upper bits read zero
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      moved_q  <= hxp_pkg::REG_RESET;
      config_q <= hxp_pkg::BYTE_W'(hxp_pkg::REG_RESET);
      iface_q  <= hxp_pkg::BYTE_W'(hxp_pkg::REG_RESET);
    end else if (usb_report_in) begin
      moved_q  <= moved_byte_count_in;
      config_q <= config_index_in;
      iface_q  <= interface_index_in;
    end
  end

  // words pushed by the processor at the fifo address leave as one-cycle pulses
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      host_word_valid_q <= 1'b0;
      host_word_q       <= '0;
    end else begin
      host_word_valid_q <= bus_write && (addr_s == hxp_pkg::FIFO_ADDR);
      if (bus_write) begin
        host_word_q <= data_s;
      end
    end
  end

  hxp_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) hxp_fifo_i (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .push_valid_in  (usb_word_valid_in),
    .push_data_in   (usb_word_in),
    .push_ready_out (usb_word_ready_out),
    .pop_valid_out  (fifo_valid),
    .pop_data_out   (fifo_word),
    .pop_in         (fifo_pop)
  );

  assign bus.wait_n      = wait_n_q;
  assign bus.dev_data    = data_q;
  assign bus.dev_data_oe = data_oe_q;

  assign xfer_mode_field_out        = mode_q;
  assign outbound_start_out         = send_addr_q;
  assign outbound_size_out          = send_count_q;
  assign inbound_start_out          = recv_addr_q;
  assign inbound_size_out           = recv_count_q;
  assign command_argument_field_out = cmd_arg_q;
  assign host_word_valid_out        = host_word_valid_q;
  assign host_word_out              = host_word_q;
endmodule : hxp_device

// >>> hxp_host.sv
// hxp_host: system-processor end; runs single register or fifo cycles on the parallel bus.
// assumes software on avalon-mm sets target and data, then writes the control register.
`timescale 1ns/1ps
module hxp_host (
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  hxp_bus_if.host          bus,
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);
  localparam int unsigned AW = hxp_pkg::ADDR_W;
  localparam int unsigned DW = hxp_pkg::DATA_W;

  typedef enum logic [2:0] {
    HS_IDLE   = 3'b000,
    HS_SETUP  = 3'b001,
    HS_SELECT = 3'b010,
    HS_WAITHI = 3'b011,
    HS_RELOE  = 3'b100,
    HS_RELCS  = 3'b101
  } hxp_host_state_t;

  hxp_host_state_t st_q;
  logic [DW:0]     in_meta_q;
  logic [DW:0]     in_sync_q;
  logic [AW-1:0]   target_q;
  logic [DW-1:0]   wdata_q;
  logic [DW-1:0]   rdata_q;
  logic            is_write_q;
  logic            busy_q;
  logic            done_q;
  logic            waitreq_q;
  logic [31:0]     readdata_q;
  logic            cs_n_q;
  logic            oe_n_q;
  logic            we_n_q;
  logic            data_oe_q;
  logic            accept;
  logic            start;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      in_meta_q <= {1'b1, {DW{1'b0}}};
      in_sync_q <= {1'b1, {DW{1'b0}}};
    end else begin
      in_meta_q <= {bus.wait_n, bus.data_bus};
      in_sync_q <= in_meta_q;
    end
  end

  // every request answers one cycle later; writes land at that edge
  assign accept = (avs_read_in || avs_write_in) && !waitreq_q;
  assign start  = accept && avs_write_in && (avs_address_in == hxp_pkg::HOST_CTRL) && !busy_q;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      waitreq_q  <= 1'b1;
      readdata_q <= '0;
    end else begin
      waitreq_q <= !((avs_read_in || avs_write_in) && waitreq_q);
      case (avs_address_in)
        hxp_pkg::HOST_TARGET: readdata_q <= 32'(target_q);
        hxp_pkg::HOST_WDATA:  readdata_q <= wdata_q;
        hxp_pkg::HOST_RDATA:  readdata_q <= rdata_q;
        hxp_pkg::HOST_STATUS: readdata_q <= {30'h0, done_q, busy_q};
        default:              readdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      target_q   <= '0;
      wdata_q    <= '0;
      is_write_q <= 1'b0;
    end else if (accept && avs_write_in && !busy_q) begin
      case (avs_address_in)
        hxp_pkg::HOST_TARGET: target_q   <= avs_writedata_in[AW-1:0];
        hxp_pkg::HOST_WDATA:  wdata_q    <= avs_writedata_in;
        hxp_pkg::HOST_CTRL:   is_write_q <= avs_writedata_in[hxp_pkg::CTRL_WRITE_BIT];
        default: ;
      endcase
    end
  end

  // one word per cycle; address settles before chip select
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_q      <= HS_IDLE;
      cs_n_q    <= 1'b1;
      oe_n_q    <= 1'b1;
      we_n_q    <= 1'b1;
      data_oe_q <= 1'b0;
      rdata_q   <= '0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            st_q   <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          we_n_q    <= !is_write_q;
          data_oe_q <= is_write_q;
          st_q      <= HS_SELECT;
        end
        HS_SELECT: begin
          cs_n_q <= 1'b0;
          oe_n_q <= is_write_q;
          // a high wait seen before the device answered is not taken as done
          if (!cs_n_q && !in_sync_q[DW]) begin
            st_q <= HS_WAITHI;
          end
        end
        HS_WAITHI: begin
          if (in_sync_q[DW]) begin
            rdata_q <= in_sync_q[DW-1:0];
            st_q    <= HS_RELOE;
          end
        end
        HS_RELOE: begin
          oe_n_q    <= 1'b1;
          we_n_q    <= 1'b1;
          data_oe_q <= 1'b0;
          st_q      <= HS_RELCS;
        end
        HS_RELCS: begin
          cs_n_q <= 1'b1;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q   <= HS_IDLE;
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign bus.cs_n         = cs_n_q;
  assign bus.oe_n         = oe_n_q;
  assign bus.we_n         = we_n_q;
  assign bus.addr         = target_q;
  assign bus.host_data    = wdata_q;
  assign bus.host_data_oe = data_oe_q;
  assign avs_readdata_out    = readdata_q;
  assign avs_waitrequest_out = waitreq_q;
endmodule : hxp_host

// >>> hxp_chk.sv
// hxp_chk: timing assertions on the parallel bus joining the host and device ends.
// assumes instantiation beside the bus interface, on the single device clock.
`timescale 1ns/1ps
module hxp_chk (
  input wire logic                       ref_clk_in,
  input wire logic                       srst_in,
  input wire logic                       cs_n,
  input wire logic                       oe_n,
  input wire logic                       we_n,
  input wire logic [hxp_pkg::ADDR_W-1:0] addr,
  input wire logic                       host_data_oe,
  input wire logic [hxp_pkg::DATA_W-1:0] dev_data,
  input wire logic                       dev_data_oe,
  input wire logic                       wait_n
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  a_stall_after_select: assert property ($fell(cs_n) |-> ##[1:6] !wait_n) else $error("no stall");
  a_release_with_data: assert property ($rose(wait_n) |-> dev_data_oe || !we_n) else $error("early release");
  // device sees the bus two flops late, so idle is judged after six cycles
  a_idle_bus_quiet: assert property (cs_n [*6] |-> wait_n && !dev_data_oe) else $error("busy when idle");
  a_word_held: assert property ($rose(dev_data_oe) |=> (dev_data_oe && $stable(dev_data)) [*3])
    else $error("word not held");
  a_addr_setup: assert property (!cs_n |-> $stable(addr)) else $error("addr moved");
  a_enable_in_select: assert property (!oe_n |-> !cs_n) else $error("oe outside cs");
  a_release_order: assert property ($rose(cs_n) |-> $past(oe_n) && $past(we_n)) else $error("cs first");
  a_no_contention: assert property (!(dev_data_oe && host_data_oe)) else $error("both drive");
  c_fifo_read: cover property (!cs_n && addr == hxp_pkg::FIFO_ADDR && dev_data_oe);
  c_write: cover property (!cs_n && !we_n && host_data_oe);
  c_stall_end: cover property ($rose(wait_n));
endmodule : hxp_chk

// >>> hxp_tb_top.sv
// hxp_tb_top: runs register and fifo cycles through the host end against the device end.
// assumes one 20 MHz clock for both ends and the usb side driven by this bench.
`timescale 1ns/1ps
module hxp_tb_top;
  localparam logic [7:0] OFS [9] = '{hxp_pkg::OFS_XFER_MODE, hxp_pkg::OFS_SEND_ADDR, hxp_pkg::OFS_SEND_COUNT,
    hxp_pkg::OFS_RECV_ADDR, hxp_pkg::OFS_RECV_COUNT, hxp_pkg::OFS_BYTES_MOVED, hxp_pkg::OFS_COMMAND_ARG,
    hxp_pkg::OFS_CONFIG_NUMBER, hxp_pkg::OFS_IFACE_NUMBER};
  localparam logic [31:0] VAL [4] = '{32'hA5A5_0001, 32'h0000_0FFF, 32'hFFFF_FFFC, 32'h8000_0000};
  logic        clk;
  logic        srst;
  logic [2:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        rpt;
  logic [31:0] rpt_cnt;
  logic [7:0]  rpt_cfg;
  logic [7:0]  rpt_ifc;
  logic        uw_valid;
  logic [31:0] uw_data;
  logic        uw_ready;
  logic [1:0]  mode_o;
  logic [31:0] buf_o [4];
  logic [7:0]  arg_o;
  logic        hw_valid;
  logic [31:0] hw_data;
  logic [31:0] hw_last;
  logic [31:0] q;
  int          hw_n;
  int          mismatches;
  int          n_checks;
  int          cycles;
  hxp_bus_if bus ();
  hxp_host hxp_host_i (.ref_clk_in(clk), .srst_in(srst), .bus(bus), .avs_address_in(av_addr),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(av_wait));
  hxp_device hxp_device_i (.ref_clk_in(clk), .srst_in(srst), .bus(bus), .usb_report_in(rpt),
    .moved_byte_count_in(rpt_cnt), .config_index_in(rpt_cfg), .interface_index_in(rpt_ifc),
    .usb_word_valid_in(uw_valid), .usb_word_in(uw_data), .usb_word_ready_out(uw_ready),
    .xfer_mode_field_out(mode_o), .outbound_start_out(buf_o[0]), .outbound_size_out(buf_o[1]),
    .inbound_start_out(buf_o[2]), .inbound_size_out(buf_o[3]), .command_argument_field_out(arg_o),
    .host_word_valid_out(hw_valid), .host_word_out(hw_data));
  hxp_chk hxp_chk_i (.ref_clk_in(clk), .srst_in(srst), .cs_n(bus.cs_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
    .addr(bus.addr), .host_data_oe(bus.host_data_oe), .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe),
    .wait_n(bus.wait_n));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (hw_valid === 1'h1) begin
      hw_last <= hw_data;
      hw_n <= hw_n + 1;
    end
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    av_addr <= a;
    av_rd <= !w;
    av_wr <= w;
    av_wdata <= d;
    // values read here are those the slave saw at this edge
    do @(posedge clk); while (av_wait !== 1'h0);
    r = av_rdata;
    av_rd <= 1'h0;
    av_wr <= 1'h0;
  endtask : av

  task automatic bus_op(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    av(hxp_pkg::HOST_TARGET, 1'h1, {24'h0, a}, r);
    av(hxp_pkg::HOST_WDATA, 1'h1, d, r);
    av(hxp_pkg::HOST_CTRL, 1'h1, {31'h0, w}, r);
    do av(hxp_pkg::HOST_STATUS, 1'h0, 32'h0, r); while (r[hxp_pkg::STAT_DONE_BIT] !== 1'h1);
    av(hxp_pkg::HOST_RDATA, 1'h0, 32'h0, r);
  endtask : bus_op

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_op(a, 1'h0, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  task automatic push(input logic [31:0] w);
    @(posedge clk);
    uw_valid <= 1'h1;
    uw_data <= w;
    do @(posedge clk); while (uw_ready !== 1'h1);
    uw_valid <= 1'h0;
  endtask : push

  task automatic reset_check();
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    foreach (OFS[i]) rd_chk(OFS[i], hxp_pkg::REG_RESET);
    chk({30'h0, mode_o}, 32'h0);
  endtask : reset_check

  initial begin
    {srst, av_addr, av_rd, av_wr, av_wdata, rpt, rpt_cnt, rpt_cfg, rpt_ifc, uw_valid, uw_data} = '0;
    srst = 1'h1;
    {hw_n, mismatches, n_checks, cycles} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    foreach (OFS[i]) rd_chk(OFS[i], hxp_pkg::REG_RESET);
    chk({31'h0, uw_ready}, 32'h1);
    $display("test reset_values done");
    bus_op(hxp_pkg::OFS_XFER_MODE, 1'h1, 32'h0000_0001, q);
    rd_chk(hxp_pkg::OFS_XFER_MODE, {30'h0, hxp_pkg::MODE_CODE_DMA});
    chk({30'h0, mode_o}, {30'h0, hxp_pkg::MODE_CODE_DMA});
    bus_op(hxp_pkg::OFS_XFER_MODE, 1'h1, 32'h0000_0002, q);
    chk({30'h0, mode_o}, {30'h0, hxp_pkg::MODE_CODE_FIFO});
    for (int i = 0; i < 4; i++) bus_op(OFS[i + 1], 1'h1, VAL[i], q);
    for (int i = 0; i < 4; i++) rd_chk(OFS[i + 1], VAL[i]);
    for (int i = 0; i < 4; i++) chk(buf_o[i], VAL[i]);
    bus_op(hxp_pkg::OFS_COMMAND_ARG, 1'h1, 32'h0000_00C3, q);
    rd_chk(hxp_pkg::OFS_COMMAND_ARG, 32'h0000_00C3);
    chk({24'h0, arg_o}, 32'h0000_00C3);
    $display("test rw_registers done");
    @(posedge clk);
    rpt <= 1'h1;
    rpt_cnt <= 32'h8000_0041;
    rpt_cfg <= 8'h5A;
    rpt_ifc <= 8'h81;
    @(posedge clk);
    rpt <= 1'h0;
    bus_op(hxp_pkg::OFS_BYTES_MOVED, 1'h1, 32'h0000_1234, q);
    rd_chk(hxp_pkg::OFS_BYTES_MOVED, 32'h8000_0041);
    rd_chk(hxp_pkg::OFS_CONFIG_NUMBER, 32'h0000_005A);
    rd_chk(hxp_pkg::OFS_IFACE_NUMBER, 32'h0000_0081);
    bus_op(8'h74, 1'h1, 32'hFFFF_FFFF, q);
    rd_chk(hxp_pkg::OFS_SEND_ADDR, VAL[0]);
    rd_chk(8'h7C, 32'h0);
    rd_chk(8'h74, 32'h0);
    $display("test ro_and_refused done");
    for (int i = 0; i < 3; i++) push(32'hF1F0_0000 + i);
    for (int i = 0; i < 3; i++) rd_chk(hxp_pkg::FIFO_ADDR, 32'hF1F0_0000 + i);
    bus_op(hxp_pkg::FIFO_ADDR, 1'h1, 32'hC0DE_0F0F, q);
    chk(hw_last, 32'hC0DE_0F0F);
    chk(hw_n, 32'h1);
    $display("test fifo done");
    reset_check();
    $display("test second_reset done");
    close_out();
  end
endmodule : hxp_tb_top
